// ===== ssbx_regs.vh
// Constants for the low-power entry and subtract-with-borrow execution block
`ifndef SSBX_REGS_VH
`define SSBX_REGS_VH
// ************************************************************
// Register offsets (APB byte addresses)
// ************************************************************
`define SSBX_OFS_CTRL 8'h00
`define SSBX_OFS_OPCODE 8'h04
`define SSBX_OFS_ACC 8'h08
`define SSBX_OFS_STATUS 8'h0C
`define SSBX_OFS_BANK 8'h10
`define SSBX_OFS_FADDR 8'h14
`define SSBX_OFS_FDATA 8'h18
`define SSBX_OFS_WDOG 8'h1C
`define SSBX_OFS_FSR2 8'h20
// ************************************************************
// Opcodes and fields
// ************************************************************
`define SSBX_OP_SLEEP 16'h0003
`define SSBX_OP_SUBB_HI 6'h15
`define SSBX_BIT_D 9
`define SSBX_BIT_A 8
`define SSBX_ILO_MAX 8'h5F
// Status layout: bit0 C, 1 DC, 2 Z, 3 OV, 4 N
`define SSBX_ST_C 0
`define SSBX_ST_DC 1
`define SSBX_ST_Z 2
`define SSBX_ST_OV 3
`define SSBX_ST_N 4
// Control layout
`define SSBX_CTRL_XINST 0
`define SSBX_CTRL_WAKE 1
// Power flags layout in control read
`define SSBX_CTRL_PWRDN 8
`define SSBX_CTRL_TMOUT 9
`define SSBX_CTRL_SLEEP 10
// ************************************************************
// Reset values and counts
// ************************************************************
`define SSBX_RST_PWRDN 1'b1
`define SSBX_RST_TMOUT 1'b1
`define SSBX_QPHASES 2'h3
`endif

// ===== ssbx_ram.v
// Register file memory of the execution block with registered read data
`timescale 1ns/1ps
module ssbx_ram #(
	parameter AW = 12,
	parameter DW = 8
) (
	input wire clk, // Core clock
	input wire we, // Write strobe
	input wire [AW-1:0] waddr, // Write address
	input wire [DW-1:0] wdata, // Write data
	input wire [AW-1:0] raddr, // Read address
	output reg [DW-1:0] rdata // Registered read data
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// Memory has no reset, so contents start undefined
	always @(posedge clk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// ===== ssbx_core.v
// Execution core for the low-power entry and subtract-with-borrow opcodes
`timescale 1ns/1ps
`include "ssbx_regs.vh"
module ssbx_core #(
	parameter WDOG_BITS = 16,
	parameter POST_BITS = 7
) (
	input wire pclk, // APB clock
	input wire presetn, // Async reset, active low
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [7:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output wire pready, // APB ready
	output wire pslverr, // APB error
	input wire wdog_expire_in, // Watchdog expiry pin, async
	output reg [WDOG_BITS-1:0] watchdog_counter_ff, // Watchdog count
	output reg sleep_ff // Low-power state
);
	// ************************************************************
	// State and declarations
	// ************************************************************
	localparam ST_IDLE = 2'b00;
	localparam ST_READ = 2'b01;
	localparam ST_EXEC = 2'b10;
	reg [1:0] state_ff;
	reg [7:0] acc_ff;
	reg [4:0] status_ff;
	reg [3:0] bank_select_reg_ff;
	reg [7:0] fsr2_ff;
	reg [15:0] opcode_ff;
	reg xinst_ff;
	reg power_down_flag_ff;
	reg time_out_flag_ff;
	reg [POST_BITS-1:0] post_ff;
	reg [11:0] faddr_ff;
	reg [1:0] qph_ff;
	reg wdog_s1_ff;
	reg wdog_s2_ff;
	reg wdog_s3_ff;
	wire wr = psel & penable & pwrite;
	wire rd_fire = psel & penable & ~pwrite;
	wire ram_we;
	wire [11:0] ram_waddr;
	wire [7:0] ram_wdata;
	wire [7:0] ram_q;
	reg [11:0] ea;

	// Map an 8-bit field and access bit to a 12-bit address
	function [11:0] eff_addr;
		input [7:0] f;
		input a;
		input xi;
		input [3:0] bank_sel;
		input [7:0] fsr2;
		begin
			if (a)
				eff_addr = {bank_sel, f};
			else if (xi && f <= `SSBX_ILO_MAX)
				eff_addr = {4'h0, fsr2 + f};
			else if (f[7])
				eff_addr = {4'hF, f};
			else
				eff_addr = {4'h0, f};
		end
	endfunction

	// Register map decode used only for the pslverr response of reads and writes
	function addr_ok;
		input [7:0] a;
		begin
			addr_ok = (a <= `SSBX_OFS_FSR2) && (a[1:0] == 2'b00);
		end
	endfunction

	// ************************************************************
	// APB slave
	// ************************************************************
	// Data reads need a RAM cycle, so the FDATA read waits one extra
	reg rd_wait_ff;
	assign pready = ~(rd_fire && paddr == `SSBX_OFS_FDATA && !rd_wait_ff);
	assign pslverr = psel & penable & pready & ~addr_ok(paddr);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rd_wait_ff <= 1'b0;
		else
			rd_wait_ff <= rd_fire && paddr == `SSBX_OFS_FDATA && !rd_wait_ff;
	end

	// Read mux, registered at every edge of a read transfer, from the setup edge on
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel && !pwrite)
		begin
			case (paddr)
				`SSBX_OFS_CTRL: prdata <= {21'h0, sleep_ff, time_out_flag_ff,
					power_down_flag_ff, 7'h0, xinst_ff};
				`SSBX_OFS_OPCODE: prdata <= {16'h0, opcode_ff};
				`SSBX_OFS_ACC: prdata <= {24'h0, acc_ff};
				`SSBX_OFS_STATUS: prdata <= {27'h0, status_ff};
				`SSBX_OFS_BANK: prdata <= {28'h0, bank_select_reg_ff};
				`SSBX_OFS_FADDR: prdata <= {20'h0, faddr_ff};
				`SSBX_OFS_FDATA: prdata <= {24'h0, ram_q};
				`SSBX_OFS_WDOG: prdata <= {{(32-WDOG_BITS){1'b0}}, watchdog_counter_ff};
				`SSBX_OFS_FSR2: prdata <= {24'h0, fsr2_ff};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	// ************************************************************
	// Watchdog expiry synchroniser
	// ************************************************************
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wdog_s1_ff <= 1'b0;
			wdog_s2_ff <= 1'b0;
			wdog_s3_ff <= 1'b0;
		end
		else
		begin
			wdog_s1_ff <= wdog_expire_in;
			wdog_s2_ff <= wdog_s1_ff;
			wdog_s3_ff <= wdog_s2_ff;
		end
	end
	wire wdog_rise = wdog_s2_ff & ~wdog_s3_ff;

	// ************************************************************
	// Execution
	// ************************************************************
	wire is_sleep = (opcode_ff == `SSBX_OP_SLEEP);
	wire is_subb = (opcode_ff[15:10] == `SSBX_OP_SUBB_HI);
	wire op_start = wr && paddr == `SSBX_OFS_OPCODE && state_ff == ST_IDLE && !sleep_ff;

	always @*
	begin
		ea = eff_addr(opcode_ff[7:0], opcode_ff[`SSBX_BIT_A], xinst_ff,
			bank_select_reg_ff, fsr2_ff);
	end

	// Subtraction with borrow; DC from the low nibble, other flags from the full result
	wire bin = ~status_ff[`SSBX_ST_C];
	wire [8:0] diff = {1'b0, acc_ff} - {1'b0, ram_q} - {8'h00, bin};
	wire [4:0] ldiff = {1'b0, acc_ff[3:0]} - {1'b0, ram_q[3:0]} - {4'h0, bin};
	wire [7:0] res = diff[7:0];
	wire ovf = (acc_ff[7] ^ ram_q[7]) & (acc_ff[7] ^ res[7]);
	wire [4:0] new_st = {res[7], ovf, (res == 8'h00), ~ldiff[4], ~diff[8]};

	wire exec = state_ff == ST_EXEC;
	assign ram_we = (exec && is_subb && opcode_ff[`SSBX_BIT_D]) ||
		(wr && paddr == `SSBX_OFS_FDATA && state_ff == ST_IDLE);
	assign ram_waddr = exec ? ea : faddr_ff;
	assign ram_wdata = exec ? res : pwdata[7:0];

	ssbx_ram #(
		.AW(12),
		.DW(8)
	) u_ram (
		.clk(pclk),
		.we(ram_we),
		.waddr(ram_waddr),
		.wdata(ram_wdata),
		.raddr(state_ff == ST_IDLE ? faddr_ff : ea),
		.rdata(ram_q)
	);

	// Sequencer: decode, read operand, execute and write
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= ST_IDLE;
			qph_ff <= 2'h0;
		end
		else
		begin
			case (state_ff)
				ST_IDLE: if (op_start) state_ff <= ST_READ;
				ST_READ: state_ff <= ST_EXEC;
				ST_EXEC: state_ff <= ST_IDLE;
				default: state_ff <= ST_IDLE;
			endcase
			qph_ff <= (state_ff == ST_IDLE) ? 2'h0 : qph_ff + 2'h1;
		end
	end

	// Architectural state and power flags
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acc_ff <= 8'h00;
			status_ff <= 5'h00;
			bank_select_reg_ff <= 4'h0;
			fsr2_ff <= 8'h00;
			opcode_ff <= 16'h0000;
			xinst_ff <= 1'b0;
			faddr_ff <= 12'h000;
			power_down_flag_ff <= `SSBX_RST_PWRDN;
			time_out_flag_ff <= `SSBX_RST_TMOUT;
			sleep_ff <= 1'b0;
			watchdog_counter_ff <= {WDOG_BITS{1'b0}};
			post_ff <= {POST_BITS{1'b0}};
		end
		else
		begin
			{watchdog_counter_ff, post_ff} <= {watchdog_counter_ff, post_ff} + 1'b1;
			if (op_start)
				opcode_ff <= pwdata[15:0];
			if (wr && state_ff == ST_IDLE)
			begin
				case (paddr)
					`SSBX_OFS_CTRL: xinst_ff <= pwdata[`SSBX_CTRL_XINST];
					`SSBX_OFS_ACC: acc_ff <= pwdata[7:0];
					`SSBX_OFS_STATUS: status_ff <= pwdata[4:0];
					`SSBX_OFS_BANK: bank_select_reg_ff <= pwdata[3:0];
					`SSBX_OFS_FADDR: faddr_ff <= pwdata[11:0];
					`SSBX_OFS_FSR2: fsr2_ff <= pwdata[7:0];
					default: ;
				endcase
			end
			if (exec && is_subb)
			begin
				status_ff <= new_st;
				if (!opcode_ff[`SSBX_BIT_D])
					acc_ff <= res;
			end
			if (exec && is_sleep)
			begin
				power_down_flag_ff <= 1'b0;
				time_out_flag_ff <= 1'b1;
				watchdog_counter_ff <= {WDOG_BITS{1'b0}};
				post_ff <= {POST_BITS{1'b0}};
				sleep_ff <= 1'b1;
			end
			else if (sleep_ff && wdog_rise)
			begin
				time_out_flag_ff <= 1'b0;
				sleep_ff <= 1'b0;
			end
			else if (sleep_ff && wr && paddr == `SSBX_OFS_CTRL && pwdata[`SSBX_CTRL_WAKE])
				sleep_ff <= 1'b0;
		end
	end
endmodule

// ===== ssbx_core_monitor.sv
// Checker for the execution block, seen from its top-level ports only
`timescale 1ns/1ps
module ssbx_core_monitor #(
	parameter WDOG_BITS = 16,
	parameter POST_BITS = 7
) (
	input wire pclk, // Clock
	input wire presetn, // Reset, active low
	input wire psel, // Select
	input wire penable, // Enable
	input wire pwrite, // Direction
	input wire [7:0] paddr, // Address
	input wire [31:0] pwdata, // Write data
	input wire [31:0] prdata, // Read data
	input wire pready, // Ready
	input wire pslverr, // Error
	input wire wdog_expire_in, // Expiry pin
	input wire [WDOG_BITS-1:0] watchdog_counter_ff, // Watchdog count
	input wire sleep_ff // Low-power state
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Taken write of the low-power opcode
	wire op_wr = psel && penable && pwrite && paddr == 8'h04 && pwdata[15:0] == 16'h0003;
	wire bad_addr = paddr > 8'h20 || paddr[1:0] != 2'h0;
	// Mirror of the counter and postscaler chain; the count only steps once per postscaler wrap
	reg [WDOG_BITS+POST_BITS-1:0] wdog_model_ff;
	reg sleep_q_ff;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wdog_model_ff <= {(WDOG_BITS+POST_BITS){1'b0}};
			sleep_q_ff <= 1'b0;
		end
		else
		begin
			sleep_q_ff <= sleep_ff;
			// Sleep entry cleared the chain one edge ago, so it now stands at one
			if (sleep_ff && !sleep_q_ff)
				wdog_model_ff <= {{(WDOG_BITS+POST_BITS-1){1'b0}}, 1'b1};
			else
				wdog_model_ff <= wdog_model_ff + 1'b1;
		end
	end
	// First access cycle of a file data read, which must stall one cycle
	sequence s_fd_first;
		psel && penable && !pwrite && paddr == 8'h18 && !$past(penable);
	endsequence
	sequence s_fd_done;
		!pready ##1 pready;
	endsequence
	a_wdog_sleep_clr: assert property ($rose(sleep_ff) |-> watchdog_counter_ff <= 1)
		else $error("watchdog not cleared on sleep entry");
	a_wdog_counts: assert property (!$rose(sleep_ff) |->
		watchdog_counter_ff == wdog_model_ff[WDOG_BITS+POST_BITS-1:POST_BITS])
		else $error("watchdog count step wrong");
	a_sleep_timing: assert property ($rose(sleep_ff) |->
		$past(op_wr, 2) || $past(op_wr, 3))
		else $error("sleep entry not tied to opcode");
	a_wake_expiry: assert property (sleep_ff && $rose(wdog_expire_in) |-> ##[1:5] !sleep_ff)
		else $error("no wake on watchdog expiry");
	a_fdata_wait: assert property (s_fd_first |-> s_fd_done)
		else $error("file data read wait wrong");
	a_ready_fast: assert property (psel && penable && !(paddr == 8'h18 && !pwrite) |-> pready)
		else $error("ready late");
	a_slverr_bad: assert property (psel && penable && pready && bad_addr |-> pslverr)
		else $error("no error on unmapped address");
	a_slverr_only: assert property (pslverr |-> psel && penable && bad_addr)
		else $error("spurious error");
endmodule
bind ssbx_core ssbx_core_monitor #(.WDOG_BITS(WDOG_BITS), .POST_BITS(POST_BITS)) i_mon (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.wdog_expire_in(wdog_expire_in), .watchdog_counter_ff(watchdog_counter_ff),
	.sleep_ff(sleep_ff));

// ===== sleep_and_subtract_borrow_exec_test.sv
// Self-checking bench for the execution block over its register bus
`timescale 1ns/1ps
module sleep_and_subtract_borrow_exec_test;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic wdog_expire_in = 1'b0;
	logic [3:0] wdog;
	logic sleep;
	logic [31:0] rdat;
	logic rerr;
	int failures = 0;
	int n_tests = 0;
	int cyc = 0;
	// Short watchdog keeps the run brief
	ssbx_core #(.WDOG_BITS(4), .POST_BITS(2)) i_ssbx_core (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .wdog_expire_in(wdog_expire_in),
		.watchdog_counter_ff(wdog), .sleep_ff(sleep));
	always #20 pclk = ~pclk;
	task end_of_test;
		begin
			if (failures == 0 && n_tests > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// Hang guard
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			failures++;
			end_of_test;
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		begin
			n_tests++;
			if (g !== e)
			begin
				failures++;
				$display("ERROR %0t got %h expected %h", $time, g, e);
			end
		end
	endtask
	// One bus transfer; an idle edge first so no signal is driven twice in a step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			// Ready, read data and error are all taken at the edge that ends the transfer
			do @(posedge pclk); while (pready !== 1'b1);
			rdat = prdata;
			rerr = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		begin
			apb(1'b0, a, 32'h0);
			chk(rdat, e);
		end
	endtask
	// Seed file, accumulator and status, run one opcode, then read all three back
	task sub(input logic [31:0] fa, fv, acc, st, op, ea, es, ef);
		begin
			apb(1'b1, 8'h14, fa);
			apb(1'b1, 8'h18, fv);
			apb(1'b1, 8'h08, acc);
			apb(1'b1, 8'h0C, st);
			apb(1'b1, 8'h04, op);
			repeat (2) @(posedge pclk);
			rd(8'h08, ea);
			rd(8'h0C, es);
			rd(8'h18, ef);
		end
	endtask
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00, 32'h300);
		apb(1'b1, 8'h10, 32'h2);
		sub(32'h210, 32'h03, 32'h02, 32'h01, 32'h5710, 32'h02, 32'h10, 32'hFF);
		sub(32'h020, 32'h02, 32'h05, 32'h01, 32'h5420, 32'h03, 32'h03, 32'h02);
		sub(32'hF90, 32'h04, 32'h05, 32'h00, 32'h5490, 32'h00, 32'h07, 32'h04);
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b1, 8'h20, 32'h30);
		sub(32'h035, 32'h01, 32'h80, 32'h01, 32'h5605, 32'h80, 32'h09, 32'h7F);
		apb(1'b1, 8'h00, 32'h0);
		rd(8'h24, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		apb(1'b1, 8'h04, 32'h0003);
		repeat (2) @(posedge pclk);
		// Look between edges so the cleared count has settled
		@(negedge pclk);
		chk({28'h0, wdog}, 32'h0);
		chk({31'h0, sleep}, 32'h1);
		rd(8'h00, 32'h600);
		apb(1'b1, 8'h00, 32'h2);
		rd(8'h00, 32'h200);
		chk({31'h0, sleep}, 32'h0);
		apb(1'b1, 8'h04, 32'h0003);
		// Expiry must arrive once the core is already asleep to count as a wake
		repeat (2) @(posedge pclk);
		wdog_expire_in <= 1'b1;
		repeat (8) @(posedge pclk);
		rd(8'h00, 32'h000);
		chk({31'h0, sleep}, 32'h0);
		wdog_expire_in <= 1'b0;
		end_of_test;
	end
endmodule
